// ==== design/bit_link_if.sv ====
/*
 * Carrier between the bus-clock capture stage and the core-clock protocol engine.
 * Assumes bit_val is stable whenever bit_tog has just changed.
 */
`timescale 1ns/1ps

interface bit_link_if;
	logic bit_val;
	logic bit_tog;

	modport capture (output bit_val, output bit_tog);
	modport core (input bit_val, input bit_tog);
endinterface : bit_link_if

// ==== design/eeprom_pkg.sv ====
/*
 * Constants, types and state encoding shared by the two-wire EEPROM target core.
 * Assumes a 250 MHz core clock and a bus clock well below a quarter of that rate.
 */
package eeprom_pkg;

	// Array geometry
	localparam int PAGE_COUNT = 128;
	localparam int PAGE_BYTES = 16;
	localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
	localparam int ADDR_W = 11;
	localparam int ROW_W = 7;
	localparam int COL_W = 4;

	// Address byte fields
	localparam int DEV_ID_MSB = 7;
	localparam int DEV_ID_LSB = 4;
	localparam int DEV_HI_MSB = 3;
	localparam int DEV_HI_LSB = 1;
	localparam int DEV_DIR_BIT = 0;

	// Bit counting within one nine-clock frame
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_BYTE_END = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [2:0] BIT_TOP = 3'h7;

	// Values after reset
	localparam logic LINE_IDLE = 1'b1;
	localparam logic WP_RESET = 1'b0;
	localparam logic TOG_RESET = 1'b0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
	localparam logic [2:0] HI_RESET = 3'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [PAGE_BYTES-1:0] MASK_RESET = 16'h0000;

	// Self-timed programming duration
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_NS = 20000;
	localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CNT_W = 24;
	localparam logic [PROG_CNT_W-1:0] PROG_CNT_RESET = 24'h000000;
	localparam logic [COL_W:0] COMMIT_RESET = 5'h10;

	typedef logic [PROG_CNT_W-1:0] prog_cnt_t;
	typedef logic [ADDR_W-1:0] addr_t;

	// Protocol phases of the target
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV_ADDR,
		ST_WORD_ADDR,
		ST_WRITE_DATA,
		ST_READ_DATA
	} state_t;

endpackage : eeprom_pkg

// ==== design/scl_bit_capture.sv ====
/*
 * Bus-clock stage: samples the data line on each rising bus clock edge.
 * Assumes the data line is stable around the rising edge, as the bus requires.
 */
`timescale 1ns/1ps

module scl_bit_capture (
	input logic scl_in,
	input logic reset_in,
	input logic sda_in,
	bit_link_if.capture link
);
	import eeprom_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Bit capture with a toggle marking each new bit
	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			link.bit_val <= LINE_IDLE;
			link.bit_tog <= TOG_RESET;
		end else begin
			link.bit_val <= sda_in; // RQ20
			link.bit_tog <= ~link.bit_tog;
		end
	end

endmodule : scl_bit_capture

// ==== design/serial_eeprom_addr_write.sv ====
/*
 * Two-wire serial EEPROM target: address decode, byte and page write, self-timed
 * programming with acknowledge polling, write protection and read entry.
 * Assumes the bus clock is a separate clock port; data line is open drain,
 * driven low only while sda_oe_n_out is low.
 */
// Behaviour
// [RQ1] Array is 128 pages of 16 bytes, 11-bit byte address.
// [RQ2] Address byte follows every Start; upper four bits compared to type identifier.
// [RQ3] Address byte bits 3..1 carry word address bits 10..8.
// [RQ4] Address byte bit 0 high starts read, low starts write.
// [RQ5] Matching address byte acknowledged; mismatch not acknowledged, back to standby.
// [RQ6] Word address byte follows address byte except current-address read; bits 7..0.
// [RQ7] Master writes: Start, write address byte, word address, data bytes.
// [RQ8] Byte write acknowledged fully; Stop then starts self-timed programming.
// [RQ9] During programming all bus input ignored, no response.
// [RQ10] Page write takes one to 16 bytes within one page.
// [RQ11] Each page data byte acknowledged; programming starts only at Stop.
// [RQ12] Only low four address bits increment, wrapping inside the page.
// [RQ13] Write address byte not acknowledged while programming, acknowledged after.
// [RQ14] Master may poll with write address bytes until acknowledged.
// [RQ15] Programming lasts until first acknowledged address; no array access meanwhile.
// [RQ16] Protect input high guards whole array; low gives no protection.
// [RQ17] Protect input sampled at Stop; later changes leave programming alone.
// [RQ18] Protected write still acknowledged; no programming, ready at once.
// [RQ19] Reads start like writes with direction high; three read kinds.
// [RQ20] Bytes travel MSB first over eight clocks, acknowledge on ninth.
// [RQ21] Address counter holds last accessed address plus one.
// [RQ22] Programming duration is a parameterised count of core clock cycles.
`timescale 1ns/1ps

module serial_eeprom_addr_write #(
	parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF,
	parameter logic [3:0] DEVICE_TYPE_ID = 4'h6 // Arbitrary value
) (
	input logic clk_in,
	input logic reset_in,
	input logic scl_in,
	input logic sda_in,
	input logic wp_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic busy_out
);
	import eeprom_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic scl_meta, scl_s, scl_prev;
	logic sda_meta, sda_s, sda_prev;
	logic wp_meta, wp_s;
	logic tog_meta, tog_s, tog_prev;
	logic start_evt, stop_evt, scl_fall, bit_evt, byte_done, ack_clk;
	logic busy, id_match, master_ack, prog_go;
	logic [3:0] bitcnt;
	logic [7:0] shift;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic [2:0] bit_sel;
	logic [2:0] hi_addr;
	logic ack_pending;
	state_t state;
	addr_t ptr;
	logic [ROW_W-1:0] page_row;
	logic [PAGE_BYTES-1:0] mask;
	logic [7:0] page_buf [PAGE_BYTES];
	logic [7:0] mem [MEM_BYTES];
	prog_cnt_t prog_cnt;
	logic [COL_W:0] commit_idx;

	bit_link_if link ();

	// Bus-clock capture stage
	scl_bit_capture capture (
		.scl_in(scl_in),
		.reset_in(reset_in),
		.sda_in(sda_in),
		.link(link.capture)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin and toggle synchronisers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			scl_meta <= LINE_IDLE;
			scl_s <= LINE_IDLE;
			scl_prev <= LINE_IDLE;
			sda_meta <= LINE_IDLE;
			sda_s <= LINE_IDLE;
			sda_prev <= LINE_IDLE;
			wp_meta <= WP_RESET;
			wp_s <= WP_RESET;
			tog_meta <= TOG_RESET;
			tog_s <= TOG_RESET;
			tog_prev <= TOG_RESET;
		end else begin
			scl_meta <= scl_in;
			scl_s <= scl_meta;
			scl_prev <= scl_s;
			sda_meta <= sda_in;
			sda_s <= sda_meta;
			sda_prev <= sda_s;
			wp_meta <= wp_in;
			wp_s <= wp_meta;
			tog_meta <= link.bit_tog;
			tog_s <= tog_meta;
			tog_prev <= tog_s;
		end
	end

	// Bus conditions and frame events
	assign start_evt = scl_s && scl_prev && sda_prev && !sda_s;
	assign stop_evt = scl_s && scl_prev && !sda_prev && sda_s;
	assign scl_fall = scl_prev && !scl_s;
	assign bit_evt = tog_s ^ tog_prev;
	assign rx_byte = {shift[6:0], link.bit_val}; // RQ20
	assign byte_done = bit_evt && (bitcnt == BIT_BYTE_END);
	assign ack_clk = bit_evt && (bitcnt == BIT_ACK);
	assign master_ack = ack_clk && (state == ST_READ_DATA) && !ack_pending && !link.bit_val; // Not our own address ack
	assign bit_sel = BIT_TOP - bitcnt[2:0];

	// Address match, blocked while programming runs
	assign busy = (prog_cnt != PROG_CNT_RESET);
	assign id_match = (rx_byte[DEV_ID_MSB:DEV_ID_LSB] == DEVICE_TYPE_ID) && !busy; // RQ2 RQ9 RQ13 RQ15

	// Programming launch: write with data, unprotected, at Stop
	assign prog_go = stop_evt && (state == ST_WRITE_DATA) && (mask != MASK_RESET) && !wp_s && !busy; // RQ17

	////////////////////////////////////////////////////////////////////////////////
	// Receive shift register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			shift <= BYTE_RESET;
		end else if (bit_evt && bitcnt != BIT_ACK) begin
			shift <= rx_byte;
		end
	end

	// Bit counter and protocol phase
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= ST_IDLE;
			bitcnt <= BIT_FIRST;
		end else if (start_evt) begin
			state <= ST_DEV_ADDR; // RQ2
			bitcnt <= BIT_FIRST;
		end else if (stop_evt) begin
			state <= ST_IDLE;
			bitcnt <= BIT_FIRST;
		end else if (ack_clk) begin
			bitcnt <= BIT_FIRST;
			if (state == ST_READ_DATA && link.bit_val) begin
				state <= ST_IDLE;
			end
		end else if (bit_evt) begin
			bitcnt <= bitcnt + 4'h1;
			if (byte_done) begin
				unique case (state)
					ST_DEV_ADDR: begin
						if (!id_match) begin
							state <= ST_IDLE; // RQ5
						end else if (rx_byte[DEV_DIR_BIT]) begin
							state <= ST_READ_DATA; // RQ4 RQ19
						end else begin
							state <= ST_WORD_ADDR; // RQ4 RQ6
						end
					end
					ST_WORD_ADDR: begin
						state <= ST_WRITE_DATA;
					end
					ST_IDLE, ST_WRITE_DATA, ST_READ_DATA: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// Acknowledge decision for the byte just received
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ack_pending <= 1'b0;
		end else if (start_evt || stop_evt || ack_clk) begin
			ack_pending <= 1'b0;
		end else if (byte_done) begin
			ack_pending <= ((state == ST_DEV_ADDR) && id_match) || (state == ST_WORD_ADDR) ||
				(state == ST_WRITE_DATA); // RQ5 RQ8 RQ11 RQ18
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data line driver, changed after the bus clock falls, released at Start or Stop
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sda_oe_n_out <= LINE_IDLE;
		end else if (start_evt || stop_evt) begin
			sda_oe_n_out <= LINE_IDLE;
		end else if (scl_fall) begin
			if (bitcnt == BIT_ACK && ack_pending) begin
				sda_oe_n_out <= 1'b0; // RQ20
			end else if (state == ST_READ_DATA && bitcnt != BIT_ACK) begin
				sda_oe_n_out <= tx_byte[bit_sel]; // RQ20
			end else begin
				sda_oe_n_out <= LINE_IDLE;
			end
		end
	end

	// Constant low level and busy flag
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sda_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			busy_out <= busy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address counter, high address bits and read data
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ptr <= ADDR_RESET;
			hi_addr <= HI_RESET;
			tx_byte <= BYTE_RESET;
		end else if (byte_done && state == ST_DEV_ADDR && id_match) begin
			if (rx_byte[DEV_DIR_BIT]) begin
				tx_byte <= mem[ptr]; // RQ19 RQ21
				ptr <= ptr + 11'h001;
			end else begin
				hi_addr <= rx_byte[DEV_HI_MSB:DEV_HI_LSB]; // RQ3
			end
		end else if (byte_done && state == ST_WORD_ADDR) begin
			ptr <= {hi_addr, rx_byte}; // RQ3 RQ6
		end else if (byte_done && state == ST_WRITE_DATA) begin
			ptr <= {ptr[ADDR_W-1:COL_W], ptr[COL_W-1:0] + 4'h1}; // RQ12
		end else if (master_ack) begin
			tx_byte <= mem[ptr]; // RQ21
			ptr <= ptr + 11'h001;
		end
	end

	// Page buffer contents
	always_ff @(posedge clk_in) begin
		if (byte_done && state == ST_WRITE_DATA) begin
			page_buf[ptr[COL_W-1:0]] <= rx_byte; // RQ10
		end
	end

	// Bytes loaded into the page buffer
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mask <= MASK_RESET;
		end else if (byte_done && state == ST_DEV_ADDR && id_match && !rx_byte[DEV_DIR_BIT]) begin
			mask <= MASK_RESET;
		end else if (byte_done && state == ST_WRITE_DATA) begin
			mask[ptr[COL_W-1:0]] <= 1'b1; // RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Self-timed programming counter and commit walk
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prog_cnt <= PROG_CNT_RESET;
			commit_idx <= COMMIT_RESET;
			page_row <= '0;
		end else if (prog_go) begin
			prog_cnt <= prog_cnt_t'(PROG_CYCLES); // RQ8 RQ11 RQ16 RQ22
			commit_idx <= '0;
			page_row <= ptr[ADDR_W-1:COL_W];
		end else if (busy) begin
			prog_cnt <= prog_cnt - 24'h000001; // RQ22
			if (!commit_idx[COL_W]) begin
				commit_idx <= commit_idx + 5'h01;
			end
		end
	end

	// Array write, one page entry per cycle
	always_ff @(posedge clk_in) begin
		if (busy && !commit_idx[COL_W] && mask[commit_idx[COL_W-1:0]]) begin
			mem[{page_row, commit_idx[COL_W-1:0]}] <= page_buf[commit_idx[COL_W-1:0]]; // RQ1
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	match_ack_a: assert property ( // RQ2 RQ5
		byte_done && state == ST_DEV_ADDR && !busy && rx_byte[DEV_ID_MSB:DEV_ID_LSB] == DEVICE_TYPE_ID
		|=> ack_pending)
		else $error("matching address byte not acknowledged");

	mismatch_idle_a: assert property ( // RQ5
		byte_done && state == ST_DEV_ADDR && rx_byte[DEV_ID_MSB:DEV_ID_LSB] != DEVICE_TYPE_ID
		|=> state == ST_IDLE && !ack_pending)
		else $error("mismatched address byte not dropped");

	busy_nack_a: assert property ( // RQ9 RQ13 RQ15
		byte_done && state == ST_DEV_ADDR && busy |=> !ack_pending && state == ST_IDLE)
		else $error("address acknowledged while programming");

	dir_select_a: assert property ( // RQ4 RQ19
		byte_done && state == ST_DEV_ADDR && id_match
		|=> state == ($past(rx_byte[DEV_DIR_BIT]) ? ST_READ_DATA : ST_WORD_ADDR))
		else $error("direction bit steered wrong phase");

	word_addr_a: assert property ( // RQ3 RQ6
		byte_done && state == ST_WORD_ADDR |=> ptr == {$past(hi_addr), $past(rx_byte)})
		else $error("word address not loaded");

	page_wrap_a: assert property ( // RQ12
		byte_done && state == ST_WRITE_DATA
		|=> ptr[ADDR_W-1:COL_W] == $past(ptr[ADDR_W-1:COL_W]) && ptr[COL_W-1:0] == $past(ptr[COL_W-1:0]) + 4'h1)
		else $error("page address did not wrap in page");

	prog_start_a: assert property ( // RQ8 RQ11 RQ17
		stop_evt && state == ST_WRITE_DATA && mask != MASK_RESET && !wp_s && !busy |=> busy ##1 busy_out)
		else $error("programming not started at stop");

	wp_skip_a: assert property ( // RQ16 RQ18
		stop_evt && wp_s && !busy |=> !busy [*2])
		else $error("protected write programmed");

	ack_drive_a: assert property ( // RQ20
		scl_fall && bitcnt == BIT_ACK && ack_pending && !start_evt && !stop_evt |=> !sda_oe_n_out)
		else $error("acknowledge not driven");

	busy_hold_a: assert property ( // RQ22
		$rose(busy) |-> busy [*8])
		else $error("programming ended too early");

	read_ptr_a: assert property ( // RQ21
		master_ack && !start_evt && !stop_evt |=> ptr == $past(ptr) + 11'h001)
		else $error("read address not advanced");

	addr_ack_hold_a: assert property ( // RQ21
		ack_clk && state == ST_READ_DATA && ack_pending && !start_evt && !stop_evt |=> ptr == $past(ptr))
		else $error("read address moved on address acknowledge");

	byte_write_c: cover property (prog_go);
	read_entry_c: cover property (byte_done && state == ST_DEV_ADDR && id_match && rx_byte[DEV_DIR_BIT]);
	protected_c: cover property (stop_evt && state == ST_WRITE_DATA && wp_s);
	poll_nack_c: cover property (byte_done && state == ST_DEV_ADDR && busy);

endmodule : serial_eeprom_addr_write

// ==== sim/bus_master_model.sv ====
/*
 * Behavioural two-wire bus master: Start, Stop and nine-clock byte frames.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps

module bus_master_model (
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	localparam realtime QTR = 31.25; // Quarter of the 125 ns bus clock

	// Idle bus: clock stands high, data released
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Start or repeated Start, clock left low
	task automatic start_cond;
		sda_low_out = 1'b0;
		#QTR scl_out = 1'b1;
		#QTR sda_low_out = 1'b1;
		#QTR scl_out = 1'b0;
		#QTR;
	endtask : start_cond

	// Stop, clock stays high afterwards
	task automatic stop_cond;
		sda_low_out = 1'b1;
		#QTR scl_out = 1'b1;
		#QTR sda_low_out = 1'b0;
		#QTR;
	endtask : stop_cond

	// Eight bits MSB first plus the ninth bit; data only moves while the clock is low
	task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
		logic [8:0] bits;
		logic [8:0] seen;
		bits = {d, nine};
		for (int i = 8; i >= 0; i--) begin
			sda_low_out = !bits[i];
			#QTR scl_out = 1'b1;
			#QTR seen[i] = sda_in;
			#QTR scl_out = 1'b0;
			#QTR;
		end
		q = seen[8:1];
		ack = seen[0];
	endtask : xfer
endmodule : bus_master_model

// ==== sim/tb.sv ====
/*
 * Self-checking bench for the two-wire EEPROM target: writes, polling, wrap, protection, reads.
 * Assumes the behavioural bus master model and a pull-up on the data wire.
 */
`timescale 1ns/1ps

module tb;
	import eeprom_pkg::*;
	localparam int PROG = 1000;
	localparam logic [3:0] TID = 4'h6; // Arbitrary type identifier
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic wp_in = 1'b0;
	logic scl, sda_low, sda_out, sda_oe_n_out, busy_out;
	wire sda = (sda_low || (!sda_oe_n_out && !sda_out)) ? 1'b0 : 1'b1;
	int error_cnt = 0;
	int comparisons = 0;
	int busy_len = 0;
	logic [7:0] q [16];

	serial_eeprom_addr_write #(.PROG_CYCLES(PROG), .DEVICE_TYPE_ID(TID)) serial_eeprom_addr_write_i (
		.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda), .wp_in(wp_in),
		.sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .busy_out(busy_out));
	bus_master_model bus_master_model_i (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda));

	// Core clock and programming-time counter
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) if (busy_out === 1'b1) busy_len <= busy_len + 1;

	////////////////////////////////////////////////////////////////////////
	// Shared tasks

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// Start plus address byte, returns the ninth-bit level
	task automatic dev_addr(input logic [10:0] a, input logic dir, output logic ak);
		logic [7:0] r;
		bus_master_model_i.start_cond();
		bus_master_model_i.xfer({TID, a[10:8], dir}, 1'b1, r, ak);
	endtask : dev_addr

	// Write address byte and word address byte, both acknowledged
	task automatic set_addr(input logic [10:0] a);
		logic ak;
		logic [7:0] r;
		dev_addr(a, 1'b0, ak);
		check(ak, 1'b0);
		bus_master_model_i.xfer(a[7:0], 1'b1, r, ak);
		check(ak, 1'b0);
	endtask : set_addr

	// Writes n bytes base+i from address a, then Stop
	task automatic write_seq(input logic [10:0] a, input int n, input logic [7:0] base);
		logic ak;
		logic [7:0] r;
		set_addr(a);
		for (int i = 0; i < n; i++) begin
			bus_master_model_i.xfer(base + 8'(i), 1'b1, r, ak);
			check(ak, 1'b0);
		end
		busy_len = 0;
		bus_master_model_i.stop_cond();
	endtask : write_seq

	// Acknowledge polling with write address bytes, then checks the busy time
	task automatic poll;
		logic ak;
		int tries;
		tries = 0;
		do begin
			dev_addr(11'h000, 1'b0, ak);
			bus_master_model_i.stop_cond();
			tries++;
		end while (ak !== 1'b0 && tries < 20);
		check(16'(tries > 1), 16'h1);
		check(ak, 1'b0);
		check(16'(busy_len), 16'(PROG));
	endtask : poll

	// Random read of n bytes from a, last byte not acknowledged
	task automatic read_seq(input logic [10:0] a, input int n);
		logic ak;
		set_addr(a);
		dev_addr(11'h000, 1'b1, ak);
		check(ak, 1'b0);
		for (int i = 0; i < n; i++) bus_master_model_i.xfer(8'hFF, i == n - 1, q[i], ak);
		bus_master_model_i.stop_cond();
	endtask : read_seq

	////////////////////////////////////////////////////////////////////////
	// Scenarios

	// Byte write, refusal while busy, polling, read back
	task automatic sc_byte_write;
		logic ak;
		write_seq(11'h5A3, 1, 8'hC4);
		dev_addr(11'h000, 1'b1, ak);
		bus_master_model_i.stop_cond();
		check(ak, 1'b1);
		check(busy_out, 1'b1);
		poll();
		read_seq(11'h5A3, 1);
		check(q[0], 8'hC4);
	endtask : sc_byte_write

	// Wrong type identifier is refused
	task automatic sc_wrong_id;
		logic ak;
		logic [7:0] r;
		bus_master_model_i.start_cond();
		bus_master_model_i.xfer({~TID, 3'h5, 1'b0}, 1'b1, r, ak);
		bus_master_model_i.stop_cond();
		check(ak, 1'b1);
		check(sda_oe_n_out, 1'b1);
	endtask : sc_wrong_id

	// Seventeen bytes from offset E wrap inside the page
	task automatic sc_page_wrap;
		logic ak;
		logic [7:0] r;
		write_seq(11'h2AE, 17, 8'h40);
		poll();
		read_seq(11'h2A0, 16);
		for (int o = 0; o < 16; o++) begin
			r = ((o + 2) % 16 == 0) ? 8'h50 : 8'(8'h40 + (o + 2) % 16);
			check(q[o], r);
		end
		read_seq(11'h2A0, 1);
		dev_addr(11'h000, 1'b1, ak);
		bus_master_model_i.xfer(8'hFF, 1'b1, r, ak);
		bus_master_model_i.stop_cond();
		check(r, 8'h43);
	endtask : sc_page_wrap

	// Protected write skipped; protect raised after Stop does not stop programming
	task automatic sc_protect;
		logic ak;
		@(posedge clk_in) wp_in <= 1'b1;
		write_seq(11'h5A3, 1, 8'h3C);
		repeat (20) @(posedge clk_in);
		check(16'(busy_len), 16'h0);
		dev_addr(11'h000, 1'b0, ak);
		bus_master_model_i.stop_cond();
		check(ak, 1'b0);
		read_seq(11'h5A3, 1);
		check(q[0], 8'hC4);
		@(posedge clk_in) wp_in <= 1'b0;
		write_seq(11'h5A3, 1, 8'h77);
		@(posedge clk_in) wp_in <= 1'b1;
		poll();
		@(posedge clk_in) wp_in <= 1'b0;
		read_seq(11'h5A3, 1);
		check(q[0], 8'h77);
	endtask : sc_protect

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog

	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		check(busy_out, 1'b0);
		check(sda_out, 1'b0);
		sc_byte_write();
		sc_wrong_id();
		sc_page_wrap();
		sc_protect();
		finish_test();
	end

	initial begin
		#300us;
		error_cnt++;
		finish_test();
	end
endmodule : tb
